/* bench/ciereg_seq_model.sv */
`timescale 1ns/1ps
`default_nettype none

module ciereg_seq_model #(
    parameter int DONE_DLY = 20
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // Command side
    input wire logic cmd_start_i,
    input wire logic [3:0] cmd_code_i,
    output logic cmd_done_o,
    // Flag writes from software
    input wire logic flag_wr_i,
    input wire logic flag_set_i,
    input wire logic [11:0] flag_mask_i,
    output logic [6:0] primary_req_o,
    output logic [4:0] secondary_req_o
);
    // ----------------------------------------
    // Sequencer and flags
    // ----------------------------------------
    int cnt;
    logic [11:0] flags;

    assign primary_req_o = flags[6:0];
    assign secondary_req_o = flags[11:7];

    always @(posedge core_clk_i) begin
        if (srst_i) begin
            cnt <= 0;
            cmd_done_o <= 1'b0;
            flags <= 12'h000;
        end else begin
            // Idle code never runs, so it never finishes
            if (cmd_start_i && cmd_code_i !== 4'h0) begin
                cnt <= DONE_DLY;
                cmd_done_o <= 1'b0;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
                cmd_done_o <= (cnt == 1);
            end else begin
                cmd_done_o <= 1'b0;
            end
            if (flag_wr_i && flag_set_i) begin
                flags <= flags | flag_mask_i;
            end else if (flag_wr_i) begin
                flags <= flags & ~flag_mask_i;
            end
        end
    end
endmodule : ciereg_seq_model

`default_nettype wire

/* bench/test_command_and_interrupt_enable_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ciereg_defines.svh"

module test_command_and_interrupt_enable_regs;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, done, start, rcv, slp, sirq, pin, oe_n;
    logic [31:0] prdata;
    logic [6:0] preq;
    logic [4:0] sreq;
    logic [3:0] code;
    logic fwr = 1'b0;
    logic fset = 1'b0;
    logic [11:0] fmask = 12'h000;
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    localparam int DLY = 20;

    always #5 clk = ~clk;

    ciereg_top DUT (.core_clk_i(clk), .srst_i(srst), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pstrb_i(pstrb), .pready_o(pready),
        .prdata_o(prdata), .pslverr_o(pslverr), .primary_req_i(preq),
        .secondary_req_i(sreq), .cmd_done_i(done), .cmd_code_o(code),
        .cmd_start_o(start), .receiver_analog_off_o(rcv),
        .soft_sleep_request_o(slp), .status_irq_o(sirq),
        .irq_pin_o(pin), .irq_pin_oe_n_o(oe_n));

    ciereg_seq_model #(.DONE_DLY(DLY)) seq (.core_clk_i(clk),
        .srst_i(srst), .cmd_start_i(start), .cmd_code_i(code),
        .cmd_done_o(done), .flag_wr_i(fwr), .flag_set_i(fset),
        .flag_mask_i(fmask), .primary_req_o(preq), .secondary_req_o(sreq));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task end_sim;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk

    // Holds the request until pready is seen high at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {24'h0, d}, r, e);
    endtask : wr

    task rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, {24'h0, exp});
    endtask : rd_chk

    task flag(input logic s, input int i);
        @(posedge clk);
        fwr <= 1'b1;
        fset <= s;
        fmask <= 12'h001 << i;
        @(posedge clk);
        fwr <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask : flag

    task wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_cyc

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        logic [31:0] r;
        logic e;
        rd_chk(`CIE_ADDR_CMD, `CIE_RST_CMD);
        rd_chk(`CIE_ADDR_PEN, `CIE_RST_PEN);
        rd_chk(`CIE_ADDR_SEN, `CIE_RST_SEN);
        chk(oe_n, 1'b1);
        chk(pready, 1'b1);
        chk(rcv, 1'b1);
        apb(1'b0, 8'h40, 32'h0, r, e);
        chk(e, 1'b1);
        wr(`CIE_ADDR_SEN, 8'hff);
        rd_chk(`CIE_ADDR_SEN, 8'h9f);
        // Low lane strobe off: the write must be dropped
        pstrb <= 4'h0;
        wr(`CIE_ADDR_SEN, 8'h00);
        pstrb <= 4'hf;
        rd_chk(`CIE_ADDR_SEN, 8'h9f);
    endtask : t_reset

    // One enable bit at a time, push-pull, no inversion; then enable bit 0 inverted, push-pull and open drain
    task t_irq;
        for (int i = 0; i < 12; i++) begin
            wr(`CIE_ADDR_PEN, (i < 7) ? (8'h01 << i) : 8'h00);
            wr(`CIE_ADDR_SEN, (i < 7) ? 8'h80 : (8'h80 | (8'h01 << (i - 7))));
            flag(1'b1, i);
            chk(sirq, 1'b1);
            chk({pin, oe_n}, 2'b10);
            wr(`CIE_ADDR_PEN, 8'h00);
            wr(`CIE_ADDR_SEN, 8'h80);
            wait_cyc(3);
            chk(sirq, 1'b0);
            flag(1'b0, i);
        end
        wr(`CIE_ADDR_PEN, 8'h81);
        wait_cyc(3);
        chk({pin, oe_n}, 2'b10);
        wr(`CIE_ADDR_SEN, 8'h00);
        wait_cyc(3);
        chk({pin, oe_n}, 2'b01);
        flag(1'b1, 0);
        chk({pin, oe_n}, 2'b00);
        flag(1'b0, 0);
    endtask : t_irq

    task t_cmd;
        wr(`CIE_ADDR_CMD, 8'hc3);
        #1;
        chk({start, code, rcv}, {1'b1, 4'h3, 1'b0});
        rd_chk(`CIE_ADDR_CMD, 8'h03);
        wait_cyc(DLY + 4);
        rd_chk(`CIE_ADDR_CMD, 8'h00);
    endtask : t_cmd

    task t_sleep;
        logic [31:0] r;
        logic e;
        int n;
        int t0;
        int dt;
        wr(`CIE_ADDR_CMD, 8'h10);
        #1;
        chk(slp, 1'b1);
        rd_chk(`CIE_ADDR_CMD, 8'h10);
        wr(`CIE_ADDR_CMD, 8'h00);
        t0 = cyc;
        rd_chk(`CIE_ADDR_CMD, 8'h10);
        n = 0;
        do begin
            apb(1'b0, `CIE_ADDR_CMD, 32'h0, r, e);
            n++;
        end while (r[4] !== 1'b0 && n < 80);
        chk(r, 32'h0);
        // Each poll takes three cycles, so the end is seen a little late
        dt = cyc - t0;
        chk(dt >= `CIE_WAKE_CYC, 1'b1);
        chk(dt <= `CIE_WAKE_CYC + 8, 1'b1);
        wr(`CIE_ADDR_CMD, {4'h0, `CIE_CMD_SOFT_RESTART});
        wr(`CIE_ADDR_CMD, {4'h1, `CIE_CMD_SOFT_RESTART});
        #1;
        chk(slp, 1'b0);
        rd_chk(`CIE_ADDR_CMD, {4'h0, `CIE_CMD_SOFT_RESTART});
        wait_cyc(DLY + 4);
        rd_chk(`CIE_ADDR_CMD, 8'h00);
    endtask : t_sleep

    // ----------------------------------------
    // Main sequence and timeout
    // ----------------------------------------
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            end_sim();
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_irq();
        t_cmd();
        t_sleep();
        end_sim();
    end
endmodule : test_command_and_interrupt_enable_regs

`default_nettype wire

/* rtl/ciereg_defines.svh */
`ifndef CIEREG_DEFINES_SVH
`define CIEREG_DEFINES_SVH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define CIE_PADDR_W 8
`define CIE_IDX_CMD 6'h01
`define CIE_IDX_PEN 6'h02
`define CIE_IDX_SEN 6'h03
`define CIE_ADDR_CMD {`CIE_IDX_CMD, 2'b00}
`define CIE_ADDR_PEN {`CIE_IDX_PEN, 2'b00}
`define CIE_ADDR_SEN {`CIE_IDX_SEN, 2'b00}

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CIE_RST_CMD 8'h20
`define CIE_RST_PEN 8'h80
`define CIE_RST_SEN 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CIE_CMD_RCV_OFF 5
`define CIE_CMD_SLEEP 4
`define CIE_CMD_CODE_HI 3
`define CIE_PEN_INVERT 7
`define CIE_SEN_DRIVE 7
`define CIE_SEN_EN_HI 4

// ----------------------------------------
// Command codes
// ----------------------------------------
`define CIE_CMD_IDLE 4'h0
// Arbitrary code for the software restart command
`define CIE_CMD_SOFT_RESTART 4'hf

// ----------------------------------------
// Timing
// ----------------------------------------
`define CIE_CLK_NS 10
`define CIE_WAKE_NS 1000
`define CIE_WAKE_CYC ((`CIE_WAKE_NS + `CIE_CLK_NS - 1) / `CIE_CLK_NS)

`endif

/* rtl/ciereg_irq_pin.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ciereg_defines.svh"

module ciereg_irq_pin (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // Control
    input wire logic status_irq_i,
    input wire logic invert_i,
    input wire logic push_pull_i,
    // Pin
    output logic irq_pin_o,
    output logic irq_pin_oe_n_o
);

    ciereg_pkg::ciereg_pin_t s;
    ciereg_pkg::ciereg_pin_t next_s;
    logic lvl;

    // ----------------------------------------
    // Pin level and driver
    // ----------------------------------------
    always_comb begin
        lvl = status_irq_i ^ invert_i;
        next_s = s;
        next_s.level = push_pull_i ? lvl : 1'b0;
        // Open drain only pulls low; high is left to the pull-up
        next_s.oe_n = push_pull_i ? 1'b0 : lvl;
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            s.level <= 1'b0;
            s.oe_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign irq_pin_o = s.level;
    assign irq_pin_oe_n_o = s.oe_n;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    pin_polarity_a: assert property (
        push_pull_i |=> !irq_pin_oe_n_o &&
            irq_pin_o == ($past(status_irq_i) ^ $past(invert_i)))
        else $error("irq pin level does not follow polarity");
    tristate_default_a: assert property (
        invert_i && !push_pull_i && !status_irq_i |=> irq_pin_oe_n_o)
        else $error("irq pin not released in default setting");
    open_drain_low_a: assert property (
        !push_pull_i && (status_irq_i == invert_i)
            |=> !irq_pin_oe_n_o && !irq_pin_o)
        else $error("open drain pin not pulled low");

endmodule : ciereg_irq_pin

`default_nettype wire

/* rtl/ciereg_pkg.sv */
package ciereg_pkg;

    // ----------------------------------------
    // Power states
    // ----------------------------------------
    typedef enum logic [2:0] {
        PWR_RUN = 3'b001,
        PWR_SLEEP = 3'b010,
        PWR_WAKE = 3'b100
    } ciereg_pwr_t;

    // ----------------------------------------
    // Register block state
    // ----------------------------------------
    typedef struct packed {
        logic [3:0] cmd_code;
        logic rcv_off;
        ciereg_pwr_t pwr;
        logic [7:0] wake_cnt;
        logic [7:0] pen;
        logic sen_drive;
        logic [4:0] sen_en;
        logic [31:0] prdata;
        logic cmd_start;
        logic status_irq;
    } ciereg_state_t;

    // ----------------------------------------
    // Pin driver state
    // ----------------------------------------
    typedef struct packed {
        logic level;
        logic oe_n;
    } ciereg_pin_t;

endpackage : ciereg_pkg

/* rtl/ciereg_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ciereg_defines.svh"

module ciereg_top (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [`CIE_PADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    // Request flags from the request-flag registers
    input wire logic [6:0] primary_req_i,
    input wire logic [4:0] secondary_req_i,
    // Command sequencer
    input wire logic cmd_done_i,
    output logic [3:0] cmd_code_o,
    output logic cmd_start_o,
    // Analog and power control
    output logic receiver_analog_off_o,
    output logic soft_sleep_request_o,
    // Interrupt
    output logic status_irq_o,
    output logic irq_pin_o,
    output logic irq_pin_oe_n_o
);

    // ----------------------------------------
    // Constants
    // ----------------------------------------
    localparam logic [7:0] WAKE_LAST = 8'(`CIE_WAKE_CYC - 1);
    localparam logic [`CIE_PADDR_W-1:0] ADDR_CMD = `CIE_ADDR_CMD;
    localparam logic [`CIE_PADDR_W-1:0] ADDR_PEN = `CIE_ADDR_PEN;
    localparam logic [`CIE_PADDR_W-1:0] ADDR_SEN = `CIE_ADDR_SEN;
    localparam logic [7:0] RST_CMD = `CIE_RST_CMD;
    localparam logic [7:0] RST_SEN = `CIE_RST_SEN;
    localparam int WAKE_MAX = 200;

    ciereg_pkg::ciereg_state_t s;
    ciereg_pkg::ciereg_state_t next_s;

    logic setup;
    logic access;
    logic hit_cmd;
    logic hit_pen;
    logic hit_sen;
    logic hit;
    logic wr_lane;
    logic wr_cmd;
    logic wr_pen;
    logic wr_sen;
    logic restart_busy;
    logic [7:0] rd_byte;
    logic [7:0] cmd_view;
    logic [7:0] sen_view;
    logic [6:0] primary_hits;
    logic [4:0] secondary_hits;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    assign setup = psel_i && !penable_i;
    assign access = psel_i && penable_i;
    assign hit_cmd = paddr_i == ADDR_CMD;
    assign hit_pen = paddr_i == ADDR_PEN;
    assign hit_sen = paddr_i == ADDR_SEN;
    assign hit = hit_cmd || hit_pen || hit_sen;
    // Registers sit in the low byte lane only
    assign wr_lane = access && pwrite_i && pstrb_i[0];
    assign wr_cmd = wr_lane && hit_cmd;
    assign wr_pen = wr_lane && hit_pen;
    assign wr_sen = wr_lane && hit_sen;

    // Zero wait states; unmapped addresses answer with an error
    assign pready_o = 1'b1;
    assign pslverr_o = access && !hit;

    // ----------------------------------------
    // Read views
    // ----------------------------------------
    // Sleep bit keeps reading 1 until wake-up is over
    always_comb begin
        cmd_view = 8'h00;
        cmd_view[`CIE_CMD_RCV_OFF] = s.rcv_off;
        cmd_view[`CIE_CMD_SLEEP] =
            s.pwr != ciereg_pkg::PWR_RUN;
        cmd_view[`CIE_CMD_CODE_HI:0] = s.cmd_code;
    end

    always_comb begin
        sen_view = 8'h00;
        sen_view[`CIE_SEN_DRIVE] = s.sen_drive;
        sen_view[`CIE_SEN_EN_HI:0] = s.sen_en;
    end

    always_comb begin
        if (hit_cmd) begin
            rd_byte = cmd_view;
        end else if (hit_pen) begin
            rd_byte = s.pen;
        end else if (hit_sen) begin
            rd_byte = sen_view;
        end else begin
            rd_byte = 8'h00;
        end
    end

    // ----------------------------------------
    // Interrupt gating
    // ----------------------------------------
    // Flags are set and cleared in the request-flag register,
    // this block only masks them
    assign primary_hits =
        primary_req_i & s.pen[6:0];
    assign secondary_hits =
        secondary_req_i & s.sen_en;

    assign restart_busy = s.cmd_code == `CIE_CMD_SOFT_RESTART;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_s = s;
        next_s.cmd_start = 1'b0;
        next_s.status_irq = |primary_hits || |secondary_hits;

        // Command finished: field falls back to idle
        if (cmd_done_i) begin
            next_s.cmd_code = `CIE_CMD_IDLE;
        end

        unique case (s.pwr)
            ciereg_pkg::PWR_RUN: begin
                next_s.wake_cnt = 8'h00;
            end
            ciereg_pkg::PWR_SLEEP: begin
                next_s.wake_cnt = 8'h00;
            end
            ciereg_pkg::PWR_WAKE: begin
                if (s.wake_cnt == WAKE_LAST) begin
                    next_s.pwr = ciereg_pkg::PWR_RUN;
                    next_s.wake_cnt = 8'h00;
                end else begin
                    next_s.wake_cnt = s.wake_cnt + 8'h01;
                end
            end
            default: begin
                next_s.pwr = ciereg_pkg::PWR_RUN;
                next_s.wake_cnt = 8'h00;
            end
        endcase

        // A host write wins over a finishing command
        if (wr_cmd) begin
            next_s.rcv_off = pwdata_i[`CIE_CMD_RCV_OFF];
            next_s.cmd_code = pwdata_i[`CIE_CMD_CODE_HI:0];
            next_s.cmd_start = 1'b1;
            if (pwdata_i[`CIE_CMD_SLEEP]) begin
                if (!restart_busy) begin
                    next_s.pwr = ciereg_pkg::PWR_SLEEP;
                    next_s.wake_cnt = 8'h00;
                end
            end else if (s.pwr == ciereg_pkg::PWR_SLEEP) begin
                next_s.pwr = ciereg_pkg::PWR_WAKE;
                next_s.wake_cnt = 8'h00;
            end
        end

        if (wr_pen) begin
            next_s.pen = pwdata_i[7:0];
        end

        if (wr_sen) begin
            next_s.sen_drive = pwdata_i[`CIE_SEN_DRIVE];
            next_s.sen_en = pwdata_i[`CIE_SEN_EN_HI:0];
        end

        // Read data captured in setup, stable through access
        if (setup && !pwrite_i) begin
            next_s.prdata = {24'h000000, rd_byte};
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            s.cmd_code <= RST_CMD[`CIE_CMD_CODE_HI:0];
            s.rcv_off <= RST_CMD[`CIE_CMD_RCV_OFF];
            s.pwr <= ciereg_pkg::PWR_RUN;
            s.wake_cnt <= 8'h00;
            s.pen <= `CIE_RST_PEN;
            s.sen_drive <= RST_SEN[`CIE_SEN_DRIVE];
            s.sen_en <= RST_SEN[`CIE_SEN_EN_HI:0];
            s.prdata <= 32'h00000000;
            s.cmd_start <= 1'b0;
            s.status_irq <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata_o = s.prdata;
    assign cmd_code_o = s.cmd_code;
    assign cmd_start_o = s.cmd_start;
    assign receiver_analog_off_o = s.rcv_off;
    assign soft_sleep_request_o = s.pwr != ciereg_pkg::PWR_RUN;
    assign status_irq_o = s.status_irq;

    // ----------------------------------------
    // Interrupt pin
    // ----------------------------------------
    ciereg_irq_pin u_irq_pin (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .status_irq_i(s.status_irq),
        .invert_i(s.pen[`CIE_PEN_INVERT]),
        .push_pull_i(s.sen_drive),
        .irq_pin_o(irq_pin_o),
        .irq_pin_oe_n_o(irq_pin_oe_n_o)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    sequence wake_asked_s;
        wr_cmd && !pwdata_i[`CIE_CMD_SLEEP] &&
            s.pwr == ciereg_pkg::PWR_SLEEP;
    endsequence

    sequence still_sleeping_s;
        soft_sleep_request_o [*8];
    endsequence

    sequence wake_ends_s;
        ##[1:WAKE_MAX] !soft_sleep_request_o;
    endsequence

    reserved_zero_a: assert property (
        setup && !pwrite_i && hit_cmd |=> prdata_o[7:6] == 2'b00)
        else $error("reserved command bits read nonzero");
    rcv_off_a: assert property (
        wr_cmd |=> receiver_analog_off_o ==
            $past(pwdata_i[`CIE_CMD_RCV_OFF]))
        else $error("receiver off bit not taken");
    sleep_enter_a: assert property (
        wr_cmd && pwdata_i[`CIE_CMD_SLEEP] && !restart_busy
            |=> s.pwr == ciereg_pkg::PWR_SLEEP)
        else $error("soft power-down not entered");
    wake_seq_a: assert property (
        wake_asked_s |=> still_sleeping_s ##0 wake_ends_s)
        else $error("wake-up sequence wrong");
    sleep_block_a: assert property (
        wr_cmd && restart_busy && s.pwr == ciereg_pkg::PWR_RUN
            |=> !soft_sleep_request_o)
        else $error("sleep set during software restart");
    cmd_start_a: assert property (
        wr_cmd |=> cmd_start_o &&
            cmd_code_o == $past(pwdata_i[`CIE_CMD_CODE_HI:0]))
        else $error("command not started with written code");
    cmd_idle_a: assert property (
        cmd_done_i && !wr_cmd |=> cmd_code_o == `CIE_CMD_IDLE)
        else $error("command field not back to idle");
    status_gate_a: assert property (
        ##1 status_irq_o == ($past(|(primary_req_i & s.pen[6:0])) ||
            $past(|(secondary_req_i & s.sen_en))))
        else $error("status interrupt does not match enabled flags");
    unmapped_err_a: assert property (
        access && !hit |-> pslverr_o && pready_o)
        else $error("unmapped access not refused");

    // ----------------------------------------
    // Write and gating checks
    // ----------------------------------------
    // A write lands at the access edge and shows one edge later;
    // between writes only the sequencer may move the command field
    pen_store_a: assert property (
        wr_pen |=> s.pen == $past(pwdata_i[7:0]))
        else $error("primary enable write not stored");
    sen_store_a: assert property (
        wr_sen |=> s.sen_drive == $past(pwdata_i[`CIE_SEN_DRIVE]) &&
            s.sen_en == $past(pwdata_i[`CIE_SEN_EN_HI:0]))
        else $error("secondary enable write not stored");
    start_pulse_a: assert property (
        !wr_cmd |=> !cmd_start_o)
        else $error("command start without a host write");
    rcv_hold_a: assert property (
        !wr_cmd |=> $stable(receiver_analog_off_o))
        else $error("receiver off bit moved without a write");
    run_stays_a: assert property (
        wr_cmd && !pwdata_i[`CIE_CMD_SLEEP] && s.pwr == ciereg_pkg::PWR_RUN
            |=> !soft_sleep_request_o)
        else $error("wake-up started while running");
    sleep_hold_a: assert property (
        s.pwr == ciereg_pkg::PWR_SLEEP && !wr_cmd
            |=> soft_sleep_request_o)
        else $error("soft power-down left without a write");
    wake_bound_a: assert property (
        s.pwr == ciereg_pkg::PWR_WAKE |-> s.wake_cnt <= WAKE_LAST)
        else $error("wake-up counter overran");
    masked_quiet_a: assert property (
        !(|s.pen[6:0]) && !(|s.sen_en) |=> !status_irq_o)
        else $error("status interrupt with all requests masked");

endmodule : ciereg_top

`default_nettype wire
